// File: logic/ssw_pkg.sv
// Purpose: shared constants and state codes of the sync SRAM front end
// Assumes: one clock, synchronous active-high reset, all inputs synchronous to clk
// Notes:   the counter is instantiated once by ssw_ctrl
`default_nettype none

package ssw_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W  = 20;
    localparam int HIGH_W  = 18;
    localparam int BURST_W = 2;
    localparam int LANES   = 4;

    // ------------------------------------------------------------
    // values after reset and fixed codes
    // ------------------------------------------------------------
    localparam logic [HIGH_W-1:0]  HIGH_RST   = 18'h00000;
    localparam logic [BURST_W-1:0] BURST_RST  = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
    localparam logic [LANES-1:0]   LANES_NONE = 4'h0;
    localparam logic [LANES-1:0]   LANES_ALL  = 4'hf;

    typedef enum logic {
        ST_DESEL,
        ST_ACTIVE
    } ssw_state_e;
endpackage

`default_nettype wire

// File: logic/ssw_burst_ctr.sv
// Purpose: two-bit burst address counter, linear or interleaved order
// Assumes: load has priority over advance
// Notes:   burst_addr_q is the current low address pair
`timescale 1ns/1ps
`default_nettype none

module ssw_burst_ctr (
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic                        load,
    input  wire logic                        advance,
    input  wire logic                        interleave,
    input  wire logic [ssw_pkg::BURST_W-1:0] base,
    output logic      [ssw_pkg::BURST_W-1:0] burst_addr_q
);
    logic [ssw_pkg::BURST_W-1:0] base_q;
    logic [ssw_pkg::BURST_W-1:0] cnt_q;
    logic [ssw_pkg::BURST_W-1:0] cnt_nx;

    assign cnt_nx = cnt_q + ssw_pkg::BURST_STEP;

    // ------------------------------------------------------------
    // counter and address
    // ------------------------------------------------------------
    // load takes the base pair, advance steps in the selected order
    always_ff @(posedge clk) begin
        if (srst) begin
            base_q       <= ssw_pkg::BURST_RST;
            cnt_q        <= ssw_pkg::BURST_RST;
            burst_addr_q <= ssw_pkg::BURST_RST;
        end else if (load) begin
            base_q       <= base;
            cnt_q        <= ssw_pkg::BURST_RST;
            burst_addr_q <= base;
        end else if (advance) begin
            cnt_q <= cnt_nx;
            if (interleave) begin
                burst_addr_q <= base_q ^ cnt_nx;
            end else begin
                burst_addr_q <= base_q + cnt_nx; // wraps within the pair
            end
        end
    end
endmodule

`default_nettype wire

// File: logic/ssw_ctrl.sv
// Purpose: input capture and write control of a flow-through burst SRAM
// Assumes: all inputs synchronous to clk; srst synchronous active high
// Notes:   all outputs registered; they show the cycle sampled at the last edge
`timescale 1ns/1ps
`default_nettype none

module ssw_ctrl (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic [ssw_pkg::HIGH_W-1:0] addr_high,
    input  wire logic                       burst_base_bit0,
    input  wire logic                       burst_base_bit1,
    input  wire logic                       primary_select_n,
    input  wire logic                       depth_select_high,
    input  wire logic                       depth_select_low_n,
    input  wire logic                       processor_addr_strobe_n,
    input  wire logic                       controller_addr_strobe_n,
    input  wire logic                       burst_advance_n,
    input  wire logic                       lane_a_write_select_n,
    input  wire logic                       lane_b_write_select_n,
    input  wire logic                       lane_c_write_select_n,
    input  wire logic                       lane_d_write_select_n,
    input  wire logic                       lane_write_qualifier_n,
    input  wire logic                       all_lanes_write_n,
    input  wire logic                       interleave_mode,
    output logic      [ssw_pkg::HIGH_W-1:0] addr_high_q,
    output logic      [ssw_pkg::BURST_W-1:0] burst_addr_q,
    output logic                            access_valid_q,
    output logic                            read_q,
    output logic      [ssw_pkg::LANES-1:0]  write_lanes_q,
    output logic                            data_float_q
);
    ssw_pkg::ssw_state_e state_q;
    ssw_pkg::ssw_state_e state_d;

    logic                      sel_ok;
    logic                      p_start;
    logic                      c_start;
    logic                      strobe;
    logic                      load;
    logic                      desel;
    logic                      burst_advance;
    logic                      active;
    logic                      access;
    logic [ssw_pkg::LANES-1:0] lanes_req;

    // ------------------------------------------------------------
    // strobe and select decode
    // ------------------------------------------------------------
    // selects only matter when a strobe asks for a new address
    assign sel_ok  = !primary_select_n && depth_select_high && !depth_select_low_n;
    assign p_start = !processor_addr_strobe_n && !primary_select_n;
    assign c_start = !controller_addr_strobe_n && !p_start;
    assign strobe  = p_start || c_start;
    assign load    = strobe && sel_ok;
    assign desel   = strobe && !sel_ok;
    assign active  = (state_q == ssw_pkg::ST_ACTIVE);
    assign burst_advance     = !strobe && active && !burst_advance_n;
    assign access  = load || (!strobe && active);

    // lane write request: all-lanes write overrides the qualified selects
    always_comb begin
        if (!all_lanes_write_n) begin
            lanes_req = ssw_pkg::LANES_ALL;
        end else if (!lane_write_qualifier_n) begin
            lanes_req = ~{lane_d_write_select_n, lane_c_write_select_n,
                          lane_b_write_select_n, lane_a_write_select_n};
        end else begin
            lanes_req = ssw_pkg::LANES_NONE;
        end
    end

    // ------------------------------------------------------------
    // selection state
    // ------------------------------------------------------------
    // a deselecting strobe ends the burst; no strobe keeps the state
    always_comb begin
        case (state_q)
            ssw_pkg::ST_DESEL: begin
                state_d = load ? ssw_pkg::ST_ACTIVE : ssw_pkg::ST_DESEL;
            end
            ssw_pkg::ST_ACTIVE: begin
                state_d = desel ? ssw_pkg::ST_DESEL : ssw_pkg::ST_ACTIVE;
            end
            default: begin
                state_d = ssw_pkg::ST_DESEL;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ssw_pkg::ST_DESEL;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // address capture
    // ------------------------------------------------------------
    // upper address held through the burst
    always_ff @(posedge clk) begin
        if (srst) begin
            addr_high_q <= ssw_pkg::HIGH_RST;
        end else if (load) begin
            addr_high_q <= addr_high;
        end
    end

    ssw_burst_ctr u_burst (
        .clk          (clk),
        .srst         (srst),
        .load         (load),
        .advance      (burst_advance),
        .interleave   (interleave_mode),
        .base         ({burst_base_bit1, burst_base_bit0}),
        .burst_addr_q (burst_addr_q)
    );

    // ------------------------------------------------------------
    // access, write and float outputs
    // ------------------------------------------------------------
    // per-cycle access type for the array
    always_ff @(posedge clk) begin
        if (srst) begin
            access_valid_q <= 1'b0;
            read_q         <= 1'b0;
            write_lanes_q  <= ssw_pkg::LANES_NONE;
        end else begin
            access_valid_q <= access;
            read_q         <= access && (lanes_req == ssw_pkg::LANES_NONE);
            write_lanes_q  <= access ? lanes_req : ssw_pkg::LANES_NONE;
        end
    end

    // data pins float on writes, on leaving deselect and while deselected
    always_ff @(posedge clk) begin
        if (srst) begin
            data_float_q <= 1'b1;
        end else begin
            data_float_q <= (state_d == ssw_pkg::ST_DESEL)
                         || (access && (lanes_req != ssw_pkg::LANES_NONE))
                         || (load && !active);
        end
    end

    // ------------------------------------------------------------
    // check helpers
    // ------------------------------------------------------------
    // burst base and step count kept apart from the counter, so order checks survive mode changes
    logic [ssw_pkg::BURST_W-1:0] chk_base_q;
    logic [ssw_pkg::BURST_W-1:0] chk_step_q;

    // reloads on every address load, counts each accepted advance
    always_ff @(posedge clk) begin
        if (srst) begin
            chk_base_q <= ssw_pkg::BURST_RST;
            chk_step_q <= ssw_pkg::BURST_RST;
        end else if (load) begin
            chk_base_q <= {burst_base_bit1, burst_base_bit0};
            chk_step_q <= ssw_pkg::BURST_RST;
        end else if (burst_advance) begin
            chk_step_q <= chk_step_q + ssw_pkg::BURST_STEP;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_load;
        load;
    endsequence

    sequence s_step_linear;
        burst_advance && !interleave_mode;
    endsequence

    sequence s_step_inter;
        burst_advance && interleave_mode;
    endsequence

    sequence s_leave_desel;
        load && !active;
    endsequence

    addr_load_a: assert property (s_load |=> addr_high_q == $past(addr_high)
        && burst_addr_q == {$past(burst_base_bit1), $past(burst_base_bit0)})
        else $error("address not captured on load");

    desel_float_a: assert property (desel |=> !access_valid_q && data_float_q)
        else $error("deselect did not stop access");

    all_lanes_a: assert property (access && !all_lanes_write_n |=> write_lanes_q == ssw_pkg::LANES_ALL)
        else $error("global write missed lanes");

    lane_qual_a: assert property (access && all_lanes_write_n && lane_write_qualifier_n
        |=> write_lanes_q == ssw_pkg::LANES_NONE && read_q)
        else $error("unqualified lane write taken");

    burst_hold_a: assert property (!strobe && active && burst_advance_n
        |=> $stable(burst_addr_q) && $stable(addr_high_q))
        else $error("burst address moved without advance");

    linear_step_a: assert property (s_step_linear
        |=> burst_addr_q == $past(chk_base_q) + $past(chk_step_q) + ssw_pkg::BURST_STEP)
        else $error("linear burst step wrong");

    inter_step_a: assert property (s_step_inter
        |=> burst_addr_q == ($past(chk_base_q) ^ ($past(chk_step_q) + ssw_pkg::BURST_STEP)))
        else $error("interleaved burst step wrong");

    desel_hold_a: assert property (!active && !load
        |=> $stable(burst_addr_q) && !access_valid_q)
        else $error("deselected cycle acted on");

    strobe_ignore_a: assert property (!processor_addr_strobe_n && primary_select_n
        && controller_addr_strobe_n |=> $stable(addr_high_q) && $stable(state_q))
        else $error("processor strobe not ignored");

    both_strobe_a: assert property (!processor_addr_strobe_n && !controller_addr_strobe_n
        && !primary_select_n && !sel_ok |=> state_q == ssw_pkg::ST_DESEL)
        else $error("both strobes not handled as processor strobe");

    first_float_a: assert property (s_leave_desel |=> data_float_q && access_valid_q)
        else $error("no float on first clock after deselect");

endmodule

`default_nettype wire

// File: test/ssw_host_model.sv
// Purpose: host side of the sram front end, drives every bus pin
// Assumes: tb hands over the next bus word before each falling edge
// Notes:   pins change only on the falling edge, never near sampling
`timescale 1ns/1ps
`default_nettype none

module ssw_host_model (
    input  wire logic        clk,
    input  wire logic [32:0] next_pins,
    output logic      [32:0] pins
);
    // ------------------------------------------------------------
    // bus drive
    // ------------------------------------------------------------
    // idle word: strobes, writes and primary select inactive, depth high set
    initial pins = 33'h000001fff;
    // bits 12..10 carry primary low, depth high, depth low
    always @(negedge clk) begin
        pins <= next_pins;
    end
endmodule

`default_nettype wire

// File: test/tb_top.sv
// Purpose: self-checking bench of the sram input capture and write control
// Assumes: outputs show the cycle sampled at the previous rising edge
// Notes:   a bench-side model predicts every output after each edge
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic                          clk;
    logic                          srst;
    logic [32:0]                   nxt;
    logic [32:0]                   p;
    logic [ssw_pkg::HIGH_W-1:0]    addr_high_q;
    logic [ssw_pkg::BURST_W-1:0]   burst_addr_q;
    logic [3:0]                    write_lanes_q;
    logic                          access_valid_q, read_q, data_float_q;
    logic [17:0]                   m_addr;
    logic [1:0]                    m_base, m_n, m_burst;
    logic [3:0]                    m_wl;
    logic                          m_act, m_acc, m_rd, m_fl;
    int                            bad_count;
    int                            compares;

    ssw_host_model i_host (.clk(clk), .next_pins(nxt), .pins(p));

    ssw_ctrl i_dut (.clk(clk), .srst(srst), .addr_high(p[32:15]), .burst_base_bit0(p[13]),
        .burst_base_bit1(p[14]), .primary_select_n(p[12]), .depth_select_high(p[11]),
        .depth_select_low_n(p[10]), .processor_addr_strobe_n(p[9]), .controller_addr_strobe_n(p[8]),
        .burst_advance_n(p[7]), .lane_a_write_select_n(p[3]), .lane_b_write_select_n(p[4]),
        .lane_c_write_select_n(p[5]), .lane_d_write_select_n(p[6]), .lane_write_qualifier_n(p[2]),
        .all_lanes_write_n(p[1]), .interleave_mode(p[0]), .addr_high_q(addr_high_q),
        .burst_addr_q(burst_addr_q), .access_valid_q(access_valid_q), .read_q(read_q),
        .write_lanes_q(write_lanes_q), .data_float_q(data_float_q));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // bus word from fields: sel = {primary_n, depth_high, depth_low_n}, stb = {proc_n, ctrl_n}
    function automatic logic [32:0] mk(logic [17:0] a, logic [1:0] b, logic [2:0] sel, logic [1:0] stb,
        logic burst_advance, logic [3:0] ln, logic q, logic g, logic il);
        return {a, b, sel, stb, burst_advance, ln, q, g, il};
    endfunction

    // predict outputs from the word sampled at this edge
    task automatic model_edge();
        logic strobe, load, first;
        strobe = (!p[9] && !p[12]) || !p[8];
        load = strobe && !p[12] && p[11] && !p[10];
        first = load && !m_act;
        m_acc = !srst && (load || (!strobe && m_act));
        if (srst) begin
            m_addr = 18'h0;
            m_base = 2'h0;
            m_n = 2'h0;
            m_burst = 2'h0;
        end else if (load) begin
            m_addr = p[32:15];
            m_base = p[14:13];
            m_n = 2'h0;
            m_burst = p[14:13];
        end else if (m_acc && !p[7]) begin
            m_n = m_n + 2'h1;
            m_burst = p[0] ? (m_base ^ m_n) : (m_base + m_n);
        end
        m_act = m_acc;
        m_wl = !m_acc ? 4'h0 : !p[1] ? 4'hf : !p[2] ? ~p[6:3] : 4'h0;
        m_rd = m_acc && (m_wl == 4'h0);
        m_fl = !m_acc || (m_wl != 4'h0) || first;
    endtask

    task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
        compares++;
        if (exp !== got) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one bus cycle: hand over a word, let it be sampled, compare results
    task automatic cyc(input logic [32:0] v);
        nxt = v;
        @(posedge clk);
        #1;
        model_edge();
        chk("addr_high_q", m_addr, addr_high_q);
        chk("burst_addr_q", 18'(m_burst), 18'(burst_addr_q));
        chk("access_valid_q", 18'(m_acc), 18'(access_valid_q));
        chk("read_q", 18'(m_rd), 18'(read_q));
        chk("write_lanes_q", 18'(m_wl), 18'(write_lanes_q));
        chk("data_float_q", 18'(m_fl), 18'(data_float_q));
    endtask

    task automatic end_sim();
        if (bad_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim();
    end

    initial begin
        logic [63:0] r;
        logic [32:0] v;
        srst = 1'b1;
        nxt = 33'h000001fff;
        bad_count = 0;
        compares = 0;
        m_act = 1'b0;
        void'($urandom(25331));
        repeat (8) cyc(33'h000001fff);
        @(negedge clk);
        srst = 1'b0;
        // idle word first, so no new word is handed over on the same falling edge as the host
        cyc(33'h000001fff);
        // corner cases: wrap, interleave, both strobes, ignored strobe, deselect
        cyc(mk(18'h2a5a5, 2'h3, 3'h2, 2'h2, 1'b1, 4'hf, 1'b1, 1'b1, 1'b0));
        repeat (4) cyc(mk(18'h3ffff, 2'h0, 3'h5, 2'h3, 1'b0, 4'ha, 1'b0, 1'b1, 1'b0));
        cyc(mk(18'h00000, 2'h2, 3'h2, 2'h3, 1'b1, 4'h0, 1'b1, 1'b0, 1'b0));
        cyc(mk(18'h01234, 2'h1, 3'h2, 2'h0, 1'b1, 4'h5, 1'b0, 1'b1, 1'b1));
        repeat (3) cyc(mk(18'h11111, 2'h0, 3'h2, 2'h3, 1'b0, 4'hf, 1'b1, 1'b1, 1'b1));
        cyc(mk(18'h22222, 2'h3, 3'h6, 2'h1, 1'b0, 4'hf, 1'b1, 1'b1, 1'b1));
        cyc(mk(18'h33333, 2'h2, 3'h3, 2'h2, 1'b0, 4'hf, 1'b1, 1'b1, 1'b0));
        cyc(mk(18'h00000, 2'h0, 3'h2, 2'h3, 1'b0, 4'hf, 1'b1, 1'b1, 1'b0));
        cyc(mk(18'h0abcd, 2'h0, 3'h2, 2'h1, 1'b0, 4'hf, 1'b1, 1'b1, 1'b0));
        // random traffic with selects mostly active and strobes now and then
        for (int i = 0; i < 3000; i++) begin
            r = {$urandom(), $urandom()};
            v = r[32:0];
            v[12] = (r[40:39] == 2'h0);
            v[11] = (r[38:37] != 2'h0);
            v[10] = (r[36:35] == 2'h0);
            v[9] = (r[34:33] != 2'h0);
            v[8] = (r[42:41] != 2'h0);
            v[1] = (r[44:43] != 2'h0);
            cyc(v);
        end
        end_sim();
    end
endmodule

`default_nettype wire
